// File: rtl/uopr_pkg.sv
/*
 package of the otg power and role swap link: register offsets, field
 positions, link vector layout and timing counts.
 assumes a single core clock of 25 mhz shared by both ends.
*/
package uopr_pkg;
   // ----------------------------------------
   // register offsets (word index = byte address)
   // ----------------------------------------
   localparam logic [7:0] UOPR_OFS_PWRC = 8'h00;  // usb_power_control
   localparam logic [7:0] UOPR_OFS_BDTP = 8'h01;  // descriptor_table_page
   localparam logic [7:0] UOPR_OFS_FRML = 8'h02;  // frame_count_low
   localparam logic [7:0] UOPR_OFS_FRMH = 8'h03;  // frame_count_high
   localparam logic [7:0] UOPR_OFS_PWM = 8'h04;   // boost_pwm_duty_period
   localparam logic [7:0] UOPR_OFS_CTL = 8'h05;   // otg role control
   localparam logic [7:0] UOPR_OFS_IRQ = 8'h06;   // interrupt_status_reg
   localparam logic [7:0] UOPR_OFS_STAT = 8'h07;  // role status
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int UOPR_PWRC_ACT = 7;    // activity_pending
   localparam int UOPR_PWRC_GUARD = 4;  // suspend_guard
   localparam int UOPR_PWRC_SUSP = 1;   // suspend_request
   localparam int UOPR_PWRC_OPEN = 0;   // operation_enable
   localparam int UOPR_IRQ_RST = 0;     // bus_reset_flag
   localparam int UOPR_IRQ_ATT = 6;     // attach_flag
   localparam int UOPR_CTL_MOD = 0;     // module_enable
   localparam int UOPR_CTL_AROLE = 1;   // this end is the a-device
   localparam int UOPR_CTL_OTG = 2;     // otg_features_enable
   localparam int UOPR_CTL_HREQ = 3;    // b: ask for host role
   localparam int UOPR_CTL_HACC = 4;    // a: hand host role over
   localparam int UOPR_CTL_DONE = 5;    // b: leave host role (pulse)
   localparam int UOPR_CTL_TRAF = 6;    // host sends frames
   localparam int UOPR_CTL_VBUS = 7;    // a: drive vbus
   localparam logic [15:0] UOPR_RST_VAL = 16'h0000;  // all registers
   // ----------------------------------------
   // link vector layout
   // ----------------------------------------
   localparam int UOPR_LNK_W = 8;
   localparam int UOPR_LNK_DP = 0;      // dplus_pullup_enable
   localparam int UOPR_LNK_DM = 1;      // dminus_pullup_enable
   localparam int UOPR_LNK_VBUS = 2;    // supply driven
   localparam int UOPR_LNK_RESET = 3;   // reset signalling
   localparam int UOPR_LNK_RESUME = 4;  // resume signalling
   localparam int UOPR_LNK_ACT = 5;     // transaction in progress
   localparam int UOPR_LNK_SOF = 6;     // frame start pulse
   localparam int UOPR_LNK_GRANT = 7;   // hnp permission
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned UOPR_CLK_KHZ = 25000;
   localparam int unsigned UOPR_FRAME_US = 1000;
   localparam int unsigned UOPR_IDLE_US = 3000;
   localparam int unsigned UOPR_RESET_US = 10000;
   localparam int unsigned UOPR_RESUME_US = 20000;
   localparam int unsigned UOPR_FRAME_CYC = UOPR_FRAME_US * UOPR_CLK_KHZ / 1000;
   localparam int unsigned UOPR_IDLE_CYC = (UOPR_IDLE_US * UOPR_CLK_KHZ + 999) / 1000;
   localparam int unsigned UOPR_RESET_CYC = (UOPR_RESET_US * UOPR_CLK_KHZ + 999) / 1000;
   localparam int unsigned UOPR_RESUME_CYC = (UOPR_RESUME_US * UOPR_CLK_KHZ + 999) / 1000;
endpackage

// File: rtl/uopr_link_if.sv
/*
 link between the otg controller end and its peer dual-role device.
 assumes both ends sample the other end's vector through synchronisers.
*/
interface uopr_link_if;
   import uopr_pkg::*;
   // ----------------------------------------
   // line state driven by each end
   // ----------------------------------------
   logic [UOPR_LNK_W-1:0] dev_drv;   // driven by the controller end
   logic [UOPR_LNK_W-1:0] peer_drv;  // driven by the peer end
   modport device_mp (output dev_drv, input peer_drv);
   modport peer_mp (output peer_drv, input dev_drv);
endinterface

// File: rtl/uopr_peer.sv
/*
 peer end: the remote host or dual-role device and its software policy.
 assumes user inputs are on core_clk; link inputs are asynchronous.
*/
module uopr_peer (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link
   uopr_link_if.peer_mp link,
   // user side
   input wire logic a_role,
   input wire logic connect,
   input wire logic low_speed,
   input wire logic vbus_req,
   input wire logic grant_hnp,
   input wire logic hnp_req,
   input wire logic traffic,
   input wire logic sof_req,
   input wire logic reset_req,
   input wire logic resume_req,
   output logic [uopr_pkg::UOPR_LNK_W-1:0] dev_seen
);
   import uopr_pkg::*;
   // ----------------------------------------
   // synchroniser: third stage confirms the second
   // ----------------------------------------
   logic [UOPR_LNK_W-1:0] s1, s2, s3;  // sync stages
   wire [UOPR_LNK_W-1:0] agree = ~(s2 ^ s3);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         dev_seen <= '0;
      end else begin
         s1 <= link.dev_drv;
         s2 <= s1;
         s3 <= s2;
         dev_seen <= (s2 & agree) | (dev_seen & ~agree);
      end
   end
   // ----------------------------------------
   // policy
   // ----------------------------------------
   // a b-peer stays off the line until the a-device powers it
   wire vbus_ok = a_role | dev_seen[UOPR_LNK_VBUS];
   // disconnect only with permission and on a full-speed link
   wire hnp_go = !a_role && hnp_req && dev_seen[UOPR_LNK_GRANT] && !low_speed;
   wire conn = connect && vbus_ok && !hnp_go;
   logic [UOPR_LNK_W-1:0] next_drv;  // line state before the output register
   always_comb begin
      next_drv = '0;
      next_drv[UOPR_LNK_DP] = conn && !low_speed;
      next_drv[UOPR_LNK_DM] = conn && low_speed;
      next_drv[UOPR_LNK_VBUS] = a_role && vbus_req;
      next_drv[UOPR_LNK_RESET] = reset_req;
      next_drv[UOPR_LNK_RESUME] = resume_req;
      next_drv[UOPR_LNK_ACT] = traffic;
      next_drv[UOPR_LNK_SOF] = sof_req;
      // low-speed links never grant a swap
      next_drv[UOPR_LNK_GRANT] = a_role && grant_hnp && !low_speed;
   end
   // output register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link.peer_drv <= '0;
      end else begin
         link.peer_drv <= next_drv;
      end
   end
endmodule

// File: rtl/uopr_device.sv
/*
 otg controller end: power control bits, data registers and the host
 negotiation role swap. assumes a register master on core_clk and a
 peer link that is asynchronous to it.
*/
module uopr_device #(
   parameter int unsigned FRAME_CYC = uopr_pkg::UOPR_FRAME_CYC,
   parameter int unsigned IDLE_CYC = uopr_pkg::UOPR_IDLE_CYC,
   parameter int unsigned RESET_CYC = uopr_pkg::UOPR_RESET_CYC,
   parameter int unsigned RESUME_CYC = uopr_pkg::UOPR_RESUME_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link
   uopr_link_if.device_mp link,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // power outputs
   output logic usb_clk_gate,
   output logic xcvr_low_power
);
   import uopr_pkg::*;
   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   if (FRAME_CYC < 2 || IDLE_CYC < 2 || RESET_CYC < 2 || RESUME_CYC < 2) begin : g_chk
      $error("uopr_device: timing counts must be at least 2");
   end
   typedef enum logic [3:0] {
      ST_OFF, ST_PERIPH, ST_B_WAIT, ST_B_RESET, ST_B_HOST, ST_B_RETURN,
      ST_A_HOST, ST_A_RESUME, ST_A_PERIPH, ST_A_SUSP, ST_A_RESET
   } uopr_state_t;
   // ----------------------------------------
   // link input synchroniser
   // ----------------------------------------
   logic [UOPR_LNK_W-1:0] s1, s2, s3;  // sync stages
   logic [UOPR_LNK_W-1:0] lnk;          // confirmed peer state
   logic sof_q;                         // previous peer frame pulse
   wire [UOPR_LNK_W-1:0] agree = ~(s2 ^ s3);
   // a change counts once stages two and three agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         lnk <= '0;
         sof_q <= 1'b0;
      end else begin
         s1 <= link.peer_drv;
         s2 <= s1;
         s3 <= s2;
         lnk <= (s2 & agree) | (lnk & ~agree);
         sof_q <= lnk[UOPR_LNK_SOF];
      end
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic act_pnd, guard, susp, op_en;  // usb_power_control bits
   logic [7:0] ctl;                    // role control
   logic [7:1] bdtp;                   // page, bit 0 fixed zero
   logic [10:0] frame;                 // frame counter
   logic [15:0] pwm;                   // duty and period
   logic bus_reset_flag, attach_flag;  // sticky events
   uopr_state_t state, next_state;
   logic [31:0] idle_cnt;              // bus idle time
   logic [31:0] st_cnt;                // time in timed states
   logic [31:0] ms_cnt;                // frame timer when host
   logic fs_link;                      // peer connected at full speed
   wire wr_pwrc = reg_wr && (reg_addr == UOPR_OFS_PWRC);
   wire wr_bdtp = reg_wr && (reg_addr == UOPR_OFS_BDTP);
   wire wr_pwm = reg_wr && (reg_addr == UOPR_OFS_PWM);
   wire wr_ctl = reg_wr && (reg_addr == UOPR_OFS_CTL);
   wire wr_irq = reg_wr && (reg_addr == UOPR_OFS_IRQ);
   // ----------------------------------------
   // status terms
   // ----------------------------------------
   wire peer_dp = lnk[UOPR_LNK_DP];
   wire peer_dm = lnk[UOPR_LNK_DM];
   wire a_role = ctl[UOPR_CTL_AROLE];
   wire host_st = (state == ST_A_HOST) || (state == ST_B_HOST);
   wire traffic = host_st && ctl[UOPR_CTL_TRAF];
   wire sof_tick = traffic && (ms_cnt == FRAME_CYC - 1);
   wire peer_sof = lnk[UOPR_LNK_SOF] && !sof_q;
   wire bus_busy = lnk[UOPR_LNK_ACT] || traffic;
   wire bus_idle = !bus_busy && !lnk[UOPR_LNK_SOF];
   wire suspended = (idle_cnt == IDLE_CYC);
   wire st_end = (st_cnt == ((state == ST_A_RESUME) ? RESUME_CYC : RESET_CYC) - 1);
   // hnp only at full speed: a b end joins on d+ alone, an a end
   // needs the peer's d+ pull-up
   wire hnp_ok = (fs_link || !a_role) && ctl[UOPR_CTL_OTG];
   // peer pulled both lines away while suspended
   wire disc_ev = (state == ST_A_HOST) && suspended && hnp_ok && !peer_dp && !peer_dm;
   wire attach_ev = ((state == ST_B_WAIT) || (state == ST_A_SUSP)) && peer_dp;
   wire peer_rst_ev = (state == ST_PERIPH) && lnk[UOPR_LNK_RESET];
   wire run = op_en && ctl[UOPR_CTL_MOD];
   wire [15:0] pwrc_rd = {8'h00, act_pnd, 2'b00, guard, 2'b00, susp, op_en};
   wire [15:0] irq_rd = {9'h000, attach_flag, 5'h00, bus_reset_flag};
   wire [15:0] stat_rd = {12'h000, state == ST_B_WAIT, fs_link, suspended, host_st};
   // low byte only on all but the pwm word
   wire [15:0] rd_val =
      (reg_addr == UOPR_OFS_PWRC) ? pwrc_rd :
      (reg_addr == UOPR_OFS_BDTP) ? {8'h00, bdtp, 1'b0} :
      (reg_addr == UOPR_OFS_FRML) ? {8'h00, frame[7:0]} :
      (reg_addr == UOPR_OFS_FRMH) ? {13'h0000, frame[10:8]} :
      (reg_addr == UOPR_OFS_PWM) ? pwm :
      (reg_addr == UOPR_OFS_CTL) ? {8'h00, ctl & 8'hdf} :
      (reg_addr == UOPR_OFS_IRQ) ? irq_rd :
      (reg_addr == UOPR_OFS_STAT) ? stat_rd : 16'h0000;
   // ----------------------------------------
   // register writes and hardware updates
   // ----------------------------------------
   // activity pending rises only if the guard lands on a busy bus
   wire act_set = wr_pwrc && reg_wdata[UOPR_PWRC_GUARD] && !guard && bus_busy;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {act_pnd, guard, susp, op_en} <= 4'h0;
      end else begin
         // set wins; drops when the caught transaction ends
         act_pnd <= act_set || (act_pnd && bus_busy && guard);
         if (wr_pwrc) begin
            guard <= reg_wdata[UOPR_PWRC_GUARD];
            op_en <= reg_wdata[UOPR_PWRC_OPEN];
         end
         // software write wins; peer wake-up clears the suspend bit
         if (wr_pwrc) begin
            susp <= reg_wdata[UOPR_PWRC_SUSP];
         end else if (lnk[UOPR_LNK_RESUME] || lnk[UOPR_LNK_RESET]) begin
            susp <= 1'b0;
         end
      end
   end
   // data and control registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= UOPR_RST_VAL[7:0];
         bdtp <= UOPR_RST_VAL[7:1];
         pwm <= UOPR_RST_VAL;
      end else begin
         if (wr_ctl) begin
            ctl <= reg_wdata[7:0];
         end else begin
            ctl[UOPR_CTL_DONE] <= 1'b0;
         end
         if (wr_bdtp) begin
            bdtp <= reg_wdata[7:1];
         end
         if (wr_pwm) begin
            pwm <= reg_wdata;
         end
      end
   end
   // sticky flags, write one to clear, a new event beats the clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_reset_flag <= 1'b0;
         attach_flag <= 1'b0;
      end else begin
         bus_reset_flag <= disc_ev || peer_rst_ev ||
            (bus_reset_flag && !(wr_irq && reg_wdata[UOPR_IRQ_RST]));
         attach_flag <= attach_ev ||
            (attach_flag && !(wr_irq && reg_wdata[UOPR_IRQ_ATT]));
      end
   end
   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rd_val : 16'h0000;
      end
   end
   // ----------------------------------------
   // timers and frame counter
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt <= '0;
         st_cnt <= '0;
         ms_cnt <= '0;
         frame <= '0;
         fs_link <= 1'b0;
      end else begin
         // idle saturates at the suspend threshold
         // idle restarts on every role change, so a fresh peripheral
         // waits the full suspend time before it lets go of d+
         idle_cnt <= (!bus_idle || next_state != state) ? '0 :
            (suspended ? idle_cnt : idle_cnt + 1);
         st_cnt <= (next_state != state) ? '0 : st_cnt + 1;
         ms_cnt <= (!traffic || sof_tick) ? '0 : ms_cnt + 1;
         if (sof_tick || (!host_st && peer_sof)) begin
            frame <= frame + 11'h001;
         end
         if (peer_dp || peer_dm) begin
            fs_link <= peer_dp && !peer_dm;
         end
      end
   end
   // ----------------------------------------
   // role state machine
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (run) begin
               next_state = a_role ? ST_A_RESET : ST_PERIPH;
            end
         end
         ST_PERIPH: begin
            // a permitted b asks for host only in suspend
            if (ctl[UOPR_CTL_HREQ] && lnk[UOPR_LNK_GRANT] && suspended && hnp_ok) begin
               next_state = ST_B_WAIT;
            end
         end
         ST_B_WAIT: begin
            if (lnk[UOPR_LNK_RESUME]) begin
               next_state = ST_PERIPH;
            end else if (peer_dp) begin
               next_state = ST_B_RESET;
            end
         end
         ST_B_RESET: begin
            if (st_end) begin
               next_state = ST_B_HOST;
            end
         end
         ST_B_HOST: begin
            if (ctl[UOPR_CTL_DONE]) begin
               next_state = ST_B_RETURN;
            end
         end
         ST_B_RETURN: begin
            next_state = ST_PERIPH;
         end
         ST_A_HOST: begin
            if (disc_ev) begin
               next_state = ctl[UOPR_CTL_HACC] ? ST_A_PERIPH : ST_A_RESUME;
            end
         end
         ST_A_RESUME: begin
            if (st_end) begin
               next_state = ST_A_HOST;
            end
         end
         ST_A_PERIPH: begin
            if (suspended) begin
               next_state = ST_A_SUSP;
            end
         end
         ST_A_SUSP: begin
            if (peer_dp) begin
               next_state = ST_A_RESET;
            end
         end
         ST_A_RESET: begin
            if (st_end) begin
               next_state = ST_A_HOST;
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
      // software drops the module first, then the enable
      if (!run) begin
         next_state = ST_OFF;
      end
   end
   // ----------------------------------------
   // link outputs, all registered
   // ----------------------------------------
   logic [UOPR_LNK_W-1:0] next_drv;
   always_comb begin
      next_drv = '0;
      // suspend bit does not touch the pull-up
      next_drv[UOPR_LNK_DP] = (state == ST_PERIPH) || (state == ST_A_PERIPH);
      next_drv[UOPR_LNK_DM] = 1'b0;
      next_drv[UOPR_LNK_VBUS] = a_role && ctl[UOPR_CTL_VBUS] && run;
      next_drv[UOPR_LNK_RESET] = (state == ST_B_RESET) || (state == ST_A_RESET);
      next_drv[UOPR_LNK_RESUME] = (state == ST_A_RESUME);
      next_drv[UOPR_LNK_ACT] = traffic;
      next_drv[UOPR_LNK_SOF] = sof_tick;
      next_drv[UOPR_LNK_GRANT] = a_role && hnp_ok && host_st;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_OFF;
         link.dev_drv <= '0;
         usb_clk_gate <= 1'b0;
         xcvr_low_power <= 1'b0;
      end else begin
         state <= next_state;
         link.dev_drv <= next_drv;
         usb_clk_gate <= susp;
         xcvr_low_power <= susp;
      end
   end
endmodule

// File: tb/uopr_checker.sv
/*
 checker for the otg link vectors between the two ends.
 assumes the bench runs short counts: reset 10, resume 12, frame 20.
*/
module uopr_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link vectors
   input wire logic [uopr_pkg::UOPR_LNK_W-1:0] dev_drv,
   input wire logic [uopr_pkg::UOPR_LNK_W-1:0] peer_drv
);
   import uopr_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // controller end line rules
   // ----------------------------------------
   chk_dm_never_up: assert property (!dev_drv[UOPR_LNK_DM])
      else $error("dm pull-up raised");
   chk_reset_no_frame: assert property (dev_drv[UOPR_LNK_RESET] |-> !dev_drv[UOPR_LNK_SOF])
      else $error("frame during reset");
   chk_reset_no_pullup: assert property (dev_drv[UOPR_LNK_RESET] |-> !dev_drv[UOPR_LNK_DP])
      else $error("pull-up during reset");
   chk_resume_no_pullup: assert property (dev_drv[UOPR_LNK_RESUME] |-> !dev_drv[UOPR_LNK_DP])
      else $error("pull-up during resume");
   // a short pulse means the reset or resume counter was cut
   chk_reset_long: assert property ($rose(dev_drv[UOPR_LNK_RESET]) |-> dev_drv[UOPR_LNK_RESET][*8])
      else $error("reset too short");
   chk_resume_long: assert property ($rose(dev_drv[UOPR_LNK_RESUME]) |-> dev_drv[UOPR_LNK_RESUME][*8])
      else $error("resume too short");
   chk_frame_gap: assert property (dev_drv[UOPR_LNK_SOF] |=> !dev_drv[UOPR_LNK_SOF][*8])
      else $error("frames too close");
   chk_quiet_pullup: assert property ($rose(dev_drv[UOPR_LNK_DP]) |-> !dev_drv[UOPR_LNK_SOF] && !dev_drv[UOPR_LNK_ACT])
      else $error("pull-up with traffic");
   // main scenarios
   cov_reset: cover property ($rose(dev_drv[UOPR_LNK_RESET]));
   cov_resume: cover property ($rose(dev_drv[UOPR_LNK_RESUME]));
   cov_drop: cover property ($fell(dev_drv[UOPR_LNK_DP]));
   cov_peer_up: cover property ($rose(peer_drv[UOPR_LNK_DP]));
endmodule

// File: tb/usb_otg_power_and_role_swap_tb.sv
/*
 bench: both ends joined by the link, registers driven over the port.
 assumes short counts so that every swap ends within a few hundred cycles.
*/
module usb_otg_power_and_role_swap_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import uopr_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic usb_clk_gate;
   logic xcvr_low_power;
   // peer pins: role,conn,ls,vbus,grant,hreq,traf,sof,rst,resume
   logic [9:0] pin = 10'h000;
   int miscompares = 0;
   int total_checks = 0;
   logic [15:0] m [0:4];  // model of data registers
   uopr_link_if link ();
   uopr_device #(.FRAME_CYC(20), .IDLE_CYC(40), .RESET_CYC(10), .RESUME_CYC(12)) u_uopr_device (
      .core_clk(core_clk), .rst_n(rst_n), .link(link.device_mp), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .usb_clk_gate(usb_clk_gate), .xcvr_low_power(xcvr_low_power));
   uopr_peer u_uopr_peer (.core_clk(core_clk), .rst_n(rst_n), .link(link.peer_mp),
      .a_role(pin[0]), .connect(pin[1]), .low_speed(pin[2]), .vbus_req(pin[3]),
      .grant_hnp(pin[4]), .hnp_req(pin[5]), .traffic(pin[6]), .sof_req(pin[7]),
      .reset_req(pin[8]), .resume_req(pin[9]), .dev_seen());
   uopr_checker u_uopr_checker (.core_clk(core_clk), .rst_n(rst_n),
      .dev_drv(link.dev_drv), .peer_drv(link.peer_drv));
   // frame pulses seen on the controller line
   int sof_seen;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sof_seen <= 0;
      end else begin
         sof_seen <= sof_seen + int'(link.dev_drv[UOPR_LNK_SOF]);
      end
   end
   always #20 core_clk = ~core_clk;
   // ----------------------------------------
   // compare, bus and wait tasks
   // ----------------------------------------
   task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_pin(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %b seen %b", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the read edge
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] mk, input logic [15:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk_reg($sformatf("reg %h", a), e & mk, reg_rdata & mk);
   endtask
   // bounded wait on a controller line, then compare
   task automatic wait_pin(input int b, input logic v, input int lim);
      int k = 0;
      #1;
      while (link.dev_drv[b] !== v && k < lim) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      chk_pin($sformatf("line %0d", b), v, link.dev_drv[b]);
   endtask
   task automatic do_reset();
      pin <= 10'h000;
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) m[i] = 16'h0000;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int a;
      logic [15:0] d;
      logic [7:0] ad;
      void'($urandom(32'h5a34c184));
      do_reset();
      for (int i = 0; i < 9; i++) rd_chk(8'(i), 16'hffff, 16'h0000);
      // random writes; index 5 stands for an unmapped place
      for (int i = 0; i < 16; i++) begin
         a = $urandom_range(0, 5);
         d = 16'($urandom);
         ad = (a == 5) ? 8'h20 : 8'(a);
         wr(ad, d);
         if (a == 0) m[0] = d & 16'h0013;
         if (a == 1) m[1] = d & 16'h00fe;
         if (a == 4) m[4] = d;
         rd_chk(ad, 16'hffff, (a < 5) ? m[a] : 16'h0000);
         chk_pin("clock gate", m[0][1], usb_clk_gate);
         chk_pin("low power", m[0][1], xcvr_low_power);
      end
      // guard set while the peer is busy; module enable is still clear
      wr(UOPR_OFS_PWRC, 16'h0000);
      pin[6] <= 1'b1;
      repeat (8) @(posedge core_clk);
      wr(UOPR_OFS_PWRC, 16'h0010);
      rd_chk(UOPR_OFS_PWRC, 16'hffff, 16'h0090);
      pin[6] <= 1'b0;
      repeat (8) @(posedge core_clk);
      rd_chk(UOPR_OFS_PWRC, 16'hffff, 16'h0010);
      // swap as b-device: low speed, resume answer, connect answer
      for (int md = 0; md < 3; md++) begin
         do_reset();
         pin <= {5'h00, 1'b1, 1'b1, md == 0, 1'b0, 1'b1};
         wr(UOPR_OFS_CTL, 16'h000d);
         wr(UOPR_OFS_PWRC, 16'h0001);
         wait_pin(UOPR_LNK_DP, 1'b1, 60);
         if (md == 0) begin
            repeat (150) @(posedge core_clk);
            rd_chk(UOPR_OFS_STAT, 16'h0003, 16'h0002);
            wait_pin(UOPR_LNK_DP, 1'b1, 0);
            // peer reset wakes the suspended module and raises the flag
            wr(UOPR_OFS_PWRC, 16'h0003);
            pin[8] <= 1'b1;
            repeat (8) @(posedge core_clk);
            rd_chk(UOPR_OFS_IRQ, 16'h0001, 16'h0001);
            chk_pin("clock gate", 1'b0, usb_clk_gate);
         end else begin
            wait_pin(UOPR_LNK_DP, 1'b0, 150);
            wait_pin(UOPR_LNK_DM, 1'b0, 0);
            pin[(md == 1) ? 9 : 1] <= 1'b1;
            if (md == 1) begin
               wait_pin(UOPR_LNK_DP, 1'b1, 100);
               rd_chk(UOPR_OFS_STAT, 16'h0001, 16'h0000);
            end else begin
               wait_pin(UOPR_LNK_RESET, 1'b1, 30);
               rd_chk(UOPR_OFS_IRQ, 16'h0040, 16'h0040);
               wait_pin(UOPR_LNK_RESET, 1'b0, 30);
               rd_chk(UOPR_OFS_STAT, 16'h0001, 16'h0001);
               // frames while hosting, counted against the line pulses
               wr(UOPR_OFS_CTL, 16'h004d);
               repeat (50) @(posedge core_clk);
               wr(UOPR_OFS_CTL, 16'h000d);
               repeat (2) @(posedge core_clk);
               rd_chk(UOPR_OFS_FRML, 16'hffff, 16'(sof_seen));
               chk_pin("frames sent", 1'b1, sof_seen != 0);
               wr(UOPR_OFS_CTL, 16'h002d);
               wait_pin(UOPR_LNK_DP, 1'b1, 30);
               rd_chk(UOPR_OFS_STAT, 16'h0001, 16'h0000);
            end
         end
      end
      // swap as a-device: hand-over answer, then resume answer
      for (int md = 0; md < 2; md++) begin
         do_reset();
         pin <= 10'h022;
         wr(UOPR_OFS_CTL, (md == 0) ? 16'h0097 : 16'h0087);
         repeat (8) @(posedge core_clk);
         #1 chk_pin("peer pull-up", 1'b0, link.peer_drv[UOPR_LNK_DP]);
         wr(UOPR_OFS_PWRC, 16'h0001);
         if (md == 0) begin
            wait_pin(UOPR_LNK_DP, 1'b1, 120);
            rd_chk(UOPR_OFS_IRQ, 16'h0001, 16'h0001);
            rd_chk(UOPR_OFS_STAT, 16'h0001, 16'h0000);
            repeat (20) @(posedge core_clk);
            wait_pin(UOPR_LNK_DP, 1'b1, 0);
            wait_pin(UOPR_LNK_DP, 1'b0, 40);
            wait_pin(UOPR_LNK_RESET, 1'b1, 4);
            rd_chk(UOPR_OFS_IRQ, 16'h0040, 16'h0040);
         end else begin
            wait_pin(UOPR_LNK_RESUME, 1'b1, 120);
            rd_chk(UOPR_OFS_IRQ, 16'h0001, 16'h0001);
            wait_pin(UOPR_LNK_RESUME, 1'b0, 20);
            rd_chk(UOPR_OFS_STAT, 16'h0001, 16'h0001);
         end
      end
      print_verdict();
   end
   // watchdog well past the expected run length
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      print_verdict();
   end
endmodule
